// file: rtl/nvsc_host.sv
// Purpose: Host controller driving a 512 x 8 nonvolatile SRAM through its pins.
// Assumes: Pin inputs synchronous to clk; one command at a time.
// Notes: Store and power-up waits are parameters so a simulation can shorten them; the recall wait is fixed.
// Operation
// - Host keeps address stable during write and output enable high.
// - Host drops write enable and chip enable together, last, entering the store state.
// - Host holds recall state at least 20 ns; device completes alone.
// - Host waits powerup recall time before SRAM access.
// - Host never holds a write state when powerup recall ends.
module nvsc_host #(
    parameter int STORE_CYCLES = nvsc_pkg::STORE_CYC,
    parameter int POWERUP_CYCLES = nvsc_pkg::POWERUP_CYC
) (
    // System.
    input wire logic clk,
    input wire logic reset,
    // Command port.
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [1:0] cmdOp,
    input wire logic [nvsc_pkg::ADDR_W-1:0] cmdAddr,
    input wire logic [nvsc_pkg::DATA_W-1:0] cmdWrData,
    output logic rdValid,
    output logic [nvsc_pkg::DATA_W-1:0] rdData,
    output logic busy,
    // Device pins.
    output logic chip_enable_n,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic nonvolatile_select_n,
    output logic [nvsc_pkg::ADDR_W-1:0] address_lines,
    output logic [nvsc_pkg::DATA_W-1:0] dataLinesOut,
    output logic dataLinesOe,
    input wire logic [nvsc_pkg::DATA_W-1:0] dataLinesIn
);
    localparam int CNT_W = 32;

    if (STORE_CYCLES < 1 || POWERUP_CYCLES < 1) begin : gen_cnt_check
        $error("nvsc_host: cycle counts must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////////
    nvsc_pkg::nvsc_state_t state_q, state_d;
    logic [1:0] op_q, op_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [nvsc_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [nvsc_pkg::DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic ce_q, ce_d, oe_q, oe_d, we_q, we_d, nv_q, nv_d, drv_q, drv_d;
    logic rdv_q, rdv_d;

    // Every access begins from standby so each store or recall sees an edge.
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        ce_d = ce_q;
        oe_d = oe_q;
        we_d = we_q;
        nv_d = nv_q;
        drv_d = drv_q;
        rdv_d = 1'b0;
        case (state_q)
            nvsc_pkg::NVSC_POWERUP: begin
                // Write enable stays high while the automatic recall runs.
                if (cnt_q >= CNT_W'(POWERUP_CYCLES - 1)) begin
                    state_d = nvsc_pkg::NVSC_IDLE;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            nvsc_pkg::NVSC_IDLE: begin
                if (cmdValid) begin
                    op_d = cmdOp;
                    addr_d = cmdAddr;
                    wdata_d = cmdWrData;
                    cnt_d = '0;
                    state_d = nvsc_pkg::NVSC_SETUP;
                    // Address settles first, with output enable high for writes.
                    case (cmdOp)
                        nvsc_pkg::CMD_WRITE: begin
                            oe_d = 1'b1;
                            drv_d = 1'b1;
                        end
                        nvsc_pkg::CMD_STORE: begin
                            oe_d = 1'b1;
                            nv_d = 1'b0;
                        end
                        nvsc_pkg::CMD_RECALL: begin
                            oe_d = 1'b0;
                            nv_d = 1'b0;
                        end
                        default: begin
                            oe_d = 1'b0;
                        end
                    endcase
                end
            end
            nvsc_pkg::NVSC_SETUP: begin
                // Chip enable arrives last, together with write enable for a write or store.
                state_d = nvsc_pkg::NVSC_PULSE;
                ce_d = 1'b0;
                we_d = !(op_q == nvsc_pkg::CMD_WRITE || op_q == nvsc_pkg::CMD_STORE);
            end
            nvsc_pkg::NVSC_PULSE: begin
                if (cnt_q >= CNT_W'(nvsc_pkg::PULSE_CYC - 1)) begin
                    cnt_d = '0;
                    state_d = nvsc_pkg::NVSC_RELEASE;
                    if (op_q == nvsc_pkg::CMD_READ) begin
                        rdata_d = dataLinesIn;
                        rdv_d = 1'b1;
                    end
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            nvsc_pkg::NVSC_RELEASE: begin
                // Write and chip enable rise together while the data is still driven.
                we_d = 1'b1;
                ce_d = 1'b1;
                oe_d = 1'b1;
                nv_d = 1'b1;
                state_d = nvsc_pkg::NVSC_WAIT;
            end
            nvsc_pkg::NVSC_WAIT: begin
                drv_d = 1'b0;
                if ((op_q == nvsc_pkg::CMD_STORE && cnt_q >= CNT_W'(STORE_CYCLES - 1)) ||
                    (op_q == nvsc_pkg::CMD_RECALL &&
                     cnt_q >= CNT_W'(nvsc_pkg::RECALL_CYC - 1)) ||
                    (op_q[1] == 1'b0 && cnt_q >= CNT_W'(nvsc_pkg::ACCESS_CYC - 1))) begin
                    state_d = nvsc_pkg::NVSC_IDLE;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: begin
                state_d = nvsc_pkg::NVSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= nvsc_pkg::NVSC_POWERUP;
            op_q <= nvsc_pkg::CMD_READ;
            cnt_q <= '0;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            ce_q <= 1'b1;
            oe_q <= 1'b1;
            we_q <= 1'b1;
            nv_q <= 1'b1;
            drv_q <= 1'b0;
            rdv_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            ce_q <= ce_d;
            oe_q <= oe_d;
            we_q <= we_d;
            nv_q <= nv_d;
            drv_q <= drv_d;
            rdv_q <= rdv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign cmdReady = (state_q == nvsc_pkg::NVSC_IDLE);
    assign busy = (state_q != nvsc_pkg::NVSC_IDLE);
    assign rdValid = rdv_q;
    assign rdData = rdata_q;
    assign chip_enable_n = ce_q;
    assign output_enable_n = oe_q;
    assign write_enable_n = we_q;
    assign nonvolatile_select_n = nv_q;
    assign address_lines = addr_q;
    assign dataLinesOut = wdata_q;
    assign dataLinesOe = drv_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_WRITE_OE_HIGH: assert property (!write_enable_n && nonvolatile_select_n |-> output_enable_n)
        else $error("output enable low during write");
    AST_DRIVE_NOT_READ: assert property (dataLinesOe |-> output_enable_n)
        else $error("data driven while output enable low");
    AST_STORE_WE_LAST: assert property ($fell(write_enable_n) && !nonvolatile_select_n
        |-> $past(!nonvolatile_select_n) && $past(output_enable_n) && output_enable_n)
        else $error("store not entered by write enable");
    AST_HOLD: assert property ($fell(chip_enable_n) |-> !chip_enable_n [*2])
        else $error("control pulse shorter than 20 ns");
    AST_ADDR_STABLE: assert property (!chip_enable_n |-> $stable(address_lines))
        else $error("address changed during access");
    AST_POWERUP_IDLE: assert property (state_q == nvsc_pkg::NVSC_POWERUP
        |-> chip_enable_n && write_enable_n)
        else $error("controls active during powerup recall");
    AST_STANDBY_AFTER: assert property ($rose(chip_enable_n) |-> chip_enable_n [*2])
        else $error("no standby gap between accesses");
    AST_NO_NOP: assert property (!(chip_enable_n == 1'b0 && output_enable_n == 1'b0 &&
        write_enable_n == 1'b0))
        else $error("no operation state driven");

    COV_READ: cover property (rdValid);
    COV_STORE: cover property ($fell(write_enable_n) && !nonvolatile_select_n);
    COV_RECALL: cover property ($fell(chip_enable_n) && !nonvolatile_select_n && write_enable_n);
endmodule

// file: rtl/nvsc_pkg.sv
// Purpose: Constants shared by the nonvolatile SRAM host controller.
// Assumes: 50 MHz system clock.
// Notes: Times are kept in their printed units; cycle counts other than ACCESS_CYC derive from them.
package nvsc_pkg;
    localparam int CLK_MHZ = 50;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int PULSE_NS = 20;
    localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam int RECALL_US = 20;
    localparam int RECALL_CYC = RECALL_US * CLK_MHZ;
    localparam int STORE_MS = 10;
    localparam int STORE_CYC = STORE_MS * 1000 * CLK_MHZ;
    localparam int POWERUP_US = 550;
    localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
    localparam int ACCESS_CYC = 3;
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_STORE = 2'h2;
    localparam logic [1:0] CMD_RECALL = 2'h3;
    typedef enum {
        NVSC_POWERUP, NVSC_IDLE, NVSC_SETUP, NVSC_PULSE, NVSC_RELEASE, NVSC_WAIT
    } nvsc_state_t;
endpackage

// file: verification/nvsc_dev_model.sv
// Purpose: Behavioural model of the 512 x 8 nonvolatile SRAM behind the host controller.
// Assumes: Pins change only just after rising clk edges; reset stands for power-up.
// Notes: Durations are short cycle counts, each below the host's own waits.
module nvsc_dev_model #(
    parameter int STORE_M = 10,
    parameter int RECALL_M = 500,
    parameter int PUP_M = 8
) (
    // System.
    input wire logic clk,
    input wire logic reset,
    input wire logic lowSupply,
    // Pins.
    input wire logic chipEnableN,
    input wire logic outputEnableN,
    input wire logic writeEnableN,
    input wire logic nvSelectN,
    input wire logic [8:0] addrLines,
    input wire logic [7:0] dataIn,
    input wire logic hostOe,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic clash
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sramQ [512];
    logic [7:0] nvQ [512];
    int timerQ;
    logic stPrev, rcPrev, wrPrev;
    logic [8:0] addrPrev;
    logic [7:0] dataPrev;
    wire stNow = !chipEnableN && !writeEnableN && !nvSelectN && outputEnableN;
    wire rcNow = !chipEnableN && !outputEnableN && !nvSelectN && writeEnableN;
    wire wrNow = !chipEnableN && !writeEnableN && nvSelectN;
    // Outputs float while busy, in write, deselected or with all controls low.
    assign dataOe = timerQ == 0 && !chipEnableN && !outputEnableN
        && writeEnableN && nvSelectN;
    assign dataOut = sramQ[addrLines];
    initial begin
        for (int i = 0; i < 512; i++) nvQ[i] = 8'(i) ^ 8'h3C;
    end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            timerQ <= PUP_M;
            for (int i = 0; i < 512; i++) sramQ[i] <= nvQ[i];
            stPrev <= 1'b1;
            rcPrev <= 1'b1;
            wrPrev <= 1'b0;
            clash <= 1'b0;
        end else begin
            stPrev <= stNow;
            rcPrev <= rcNow;
            wrPrev <= wrNow;
            addrPrev <= addrLines;
            dataPrev <= dataIn;
            clash <= clash | (dataOe & hostOe);
            if (timerQ != 0) begin
                timerQ <= timerQ - 1;
            end else if (stNow && !stPrev && !lowSupply) begin
                timerQ <= STORE_M;
                for (int i = 0; i < 512; i++) nvQ[i] <= sramQ[i];
            end else if (rcNow && !rcPrev) begin
                timerQ <= RECALL_M;
                for (int i = 0; i < 512; i++) sramQ[i] <= nvQ[i];
            end else if (wrPrev && !wrNow) begin
                sramQ[addrPrev] <= dataPrev;
            end
        end
    end
endmodule

// file: verification/nvsc_host_tb.sv
// Purpose: Self-checking bench for the nonvolatile SRAM host controller.
// Assumes: Device model answers on the pins; store and power-up waits are shortened by parameters.
// Notes: Inputs change on falling edges only.
module nvsc_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(got, want) begin checksDone++; if ((got) !== (want)) begin errorCnt++; \
        $display("unexpected at %0t got %0h want %0h", $time, got, want); end end
    logic clk, reset, cmdValid, cmdReady, rdValid, busy, hostOe, devOe, clash, lowSupply;
    logic ceN, oeN, weN, nvN;
    logic [1:0] cmdOp;
    logic [8:0] cmdAddr, addrLines;
    logic [7:0] cmdWrData, rdData, hostOut, devOut;
    wire [7:0] dataIn = hostOe ? hostOut : (devOe ? devOut : ~devOut);
    int errorCnt = 0;
    int checksDone = 0;
    int cycles = 0;
    nvsc_host #(.STORE_CYCLES(20), .POWERUP_CYCLES(10)) nvsc_host_inst (.clk(clk),
        .reset(reset), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
        .cmdAddr(cmdAddr), .cmdWrData(cmdWrData), .rdValid(rdValid), .rdData(rdData),
        .busy(busy), .chip_enable_n(ceN), .output_enable_n(oeN), .write_enable_n(weN),
        .nonvolatile_select_n(nvN), .address_lines(addrLines), .dataLinesOut(hostOut),
        .dataLinesOe(hostOe), .dataLinesIn(dataIn));
    nvsc_dev_model nvsc_dev_model_inst (.clk(clk), .reset(reset), .lowSupply(lowSupply),
        .chipEnableN(ceN), .outputEnableN(oeN), .writeEnableN(weN), .nvSelectN(nvN),
        .addrLines(addrLines), .dataIn(dataIn), .hostOe(hostOe), .dataOut(devOut),
        .dataOe(devOe), .clash(clash));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic giveVerdict();
        if (errorCnt == 0 && checksDone > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Issues one command and, for a read, returns the byte that came back.
    task automatic doCmd(input logic [1:0] op, input logic [8:0] a, input logic [7:0] d,
                         output logic [7:0] rd);
        int n;
        n = 0;
        while (cmdReady !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        cmdValid = 1'b1;
        cmdOp = op;
        cmdAddr = a;
        cmdWrData = d;
        @(negedge clk);
        cmdValid = 1'b0;
        while (op == nvsc_pkg::CMD_READ && rdValid !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000) begin
            errorCnt++;
            giveVerdict();
        end else begin
            rd = rdData;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tPowerup();
        logic [7:0] r;
        `CHK(busy, 1'b1)
        `CHK(cmdReady, 1'b0)
        doCmd(nvsc_pkg::CMD_READ, 9'h007, 8'h00, r);
        `CHK(r, 8'h3B)
    endtask
    task automatic tReadWrite();
        logic [7:0] r;
        logic [8:0] al [3];
        al = '{9'h000, 9'h1FF, 9'h0AA};
        for (int i = 0; i < 3; i++) doCmd(nvsc_pkg::CMD_WRITE, al[i], 8'hA0 + 8'(i), r);
        for (int i = 0; i < 3; i++) begin
            doCmd(nvsc_pkg::CMD_READ, al[i], 8'h00, r);
            `CHK(r, 8'hA0 + 8'(i))
        end
    endtask
    task automatic tStoreRecall();
        logic [7:0] r;
        doCmd(nvsc_pkg::CMD_WRITE, 9'h003, 8'h11, r);
        doCmd(nvsc_pkg::CMD_STORE, 9'h000, 8'h00, r);
        `CHK(busy, 1'b1)
        doCmd(nvsc_pkg::CMD_WRITE, 9'h003, 8'h22, r);
        doCmd(nvsc_pkg::CMD_READ, 9'h003, 8'h00, r);
        `CHK(r, 8'h22)
        doCmd(nvsc_pkg::CMD_RECALL, 9'h000, 8'h00, r);
        `CHK(busy, 1'b1)
        doCmd(nvsc_pkg::CMD_READ, 9'h003, 8'h00, r);
        `CHK(r, 8'h11)
        doCmd(nvsc_pkg::CMD_WRITE, 9'h1FF, 8'h55, r);
        doCmd(nvsc_pkg::CMD_RECALL, 9'h000, 8'h00, r);
        doCmd(nvsc_pkg::CMD_READ, 9'h1FF, 8'h00, r);
        `CHK(r, 8'hA1)
    endtask
    task automatic tStoreInhibit();
        logic [7:0] r;
        doCmd(nvsc_pkg::CMD_WRITE, 9'h003, 8'h33, r);
        lowSupply = 1'b1;
        doCmd(nvsc_pkg::CMD_STORE, 9'h000, 8'h00, r);
        doCmd(nvsc_pkg::CMD_READ, 9'h003, 8'h00, r);
        `CHK(r, 8'h33)
        lowSupply = 1'b0;
        doCmd(nvsc_pkg::CMD_RECALL, 9'h000, 8'h00, r);
        doCmd(nvsc_pkg::CMD_READ, 9'h003, 8'h00, r);
        `CHK(r, 8'h11)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errorCnt++;
            giveVerdict();
        end
    end
    initial begin
        reset = 1'b1;
        lowSupply = 1'b0;
        cmdValid = 1'b0;
        cmdOp = 2'h0;
        cmdAddr = 9'h000;
        cmdWrData = 8'h00;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        tPowerup();
        tReadWrite();
        tStoreRecall();
        tStoreInhibit();
        `CHK(clash, 1'b0)
        giveVerdict();
    end
endmodule
